// >>> design/ssr_err_fifo.v
// Purpose: First-in first-out store for error messages.
// Assumes: Push, pop and clear are one-cycle pulses on the block clock.
// Notes:   A push into a full store is dropped and reported, unless a pop or a clear comes in the same cycle.
`include "ssr_map.vh"
module ssr_err_fifo (
  input  wire                 clk_i,
  input  wire                 rst_i,
  input  wire                 clr_i,
  input  wire                 push_i,
  input  wire [`SSR_MSG_W-1:0] wdat_i,
  input  wire                 pop_i,
  output wire [`SSR_MSG_W-1:0] rdat_o,
  output wire                 empty_o,
  output wire                 full_o,
  output wire                 ovf_o
);
  reg [`SSR_MSG_W-1:0] mem [0:`SSR_Q_DEPTH-1];
  reg [`SSR_Q_AW-1:0]  wp_q;
  reg [`SSR_Q_AW-1:0]  rp_q;
  reg [`SSR_Q_AW:0]    cnt_q;
  wire                 do_push;
  wire                 do_pop;

  assign empty_o = (cnt_q == 4'h0);
  assign full_o  = (cnt_q == `SSR_Q_DEPTH);
  assign do_pop  = pop_i & ~empty_o;
  // A pop frees a slot in the same cycle, so a full store can still take one.
  assign do_push = push_i & (~full_o | do_pop);
  assign ovf_o   = push_i & ~do_push & ~clr_i;
  assign rdat_o  = mem[rp_q];

  always @(posedge clk_i) begin
    if (do_push & ~clr_i) begin
      mem[wp_q] <= wdat_i;
    end
  end

  // Pointer and count update; clear discards everything held.
  always @(posedge clk_i) begin
    if (rst_i | clr_i) begin
      wp_q  <= 3'h0;
      rp_q  <= 3'h0;
      cnt_q <= 4'h0;
    end else begin
      if (do_push) wp_q <= wp_q + 3'h1;
      if (do_pop)  rp_q <= rp_q + 3'h1;
      cnt_q <= cnt_q + {3'h0, do_push} - {3'h0, do_pop};
    end
  end
endmodule // ssr_err_fifo

// >>> design/ssr_map.vh
// Purpose: Register map and field constants of the status and error block.
// Assumes: Wishbone byte addresses, 32-bit data, one word per register.
// Notes:   Definitions only.
`ifndef SSR_MAP_VH
`define SSR_MAP_VH
// Register byte offsets.
`define SSR_A_CMD     8'h00
`define SSR_A_GRP     8'h10
`define SSR_A_GSTEP   8'h10
`define SSR_O_EVT     8'h00
`define SSR_O_EN      8'h04
`define SSR_O_COND    8'h08
`define SSR_A_QNEXT   8'h40
`define SSR_A_QEN     8'h44
`define SSR_A_QDIS    8'h48
`define SSR_A_SYSERR  8'h4C
`define SSR_A_SYS     8'h50
`define SSR_A_IRQST   8'h54
`define SSR_A_IRQCLR  8'h58
`define SSR_A_IRQEN   8'h5C
// Command register bits.
`define SSR_CMD_CLS   0
`define SSR_CMD_PRE   1
`define SSR_CMD_QCLR  2
// System register fields.
`define SSR_SYS_POS_L 0
`define SSR_SYS_POS_H 2
`define SSR_SYS_PROT  3
`define SSR_SYS_AZ    4
`define SSR_SYS_BOTH  5
`define SSR_SYS_CONT  6
`define SSR_SYS_DISP  7
// Power-on setup codes: 0 factory, 1 + slot for saved slots.
`define SSR_POS_FACT  3'h0
`define SSR_POS_SLOTS 3'h5
// Message layout: type in the top nibble.
`define SSR_MSG_W     16
`define SSR_TYPE_H    15
`define SSR_TYPE_L    12
`define SSR_Q_DEPTH   8
`define SSR_Q_AW      3
`define SSR_Q_VALID   31
// Interrupt status bits.
`define SSR_IRQ_QUEUED 0
`define SSR_IRQ_OVF    1
`define SSR_IRQ_STAT   2
`define SSR_IRQ_W      3
`endif

// >>> design/ssr_status_group.v
// Purpose: One status group: condition, event and enable registers.
// Assumes: Condition bits come from logic on the same clock.
// Notes:   Events latch on a rising condition bit.
`include "ssr_map.vh"
module ssr_status_group (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [15:0] cond_i,
  input  wire        clr_evt_i,
  input  wire        clr_en_i,
  input  wire        en_we_i,
  input  wire [15:0] en_mask_i,
  input  wire [15:0] en_wdat_i,
  output reg  [15:0] evt_o,
  output reg  [15:0] en_o,
  output wire        sum_o
);
  reg [15:0] cond_q;

  // Rising edge latch; a new edge beats a clear in the same cycle.
  always @(posedge clk_i) begin
    if (rst_i) begin
      cond_q <= 16'h0000;
      evt_o  <= 16'h0000;
      en_o   <= 16'h0000;
    end else begin
      cond_q <= cond_i;
      evt_o  <= (clr_evt_i ? 16'h0000 : evt_o) | (cond_i & ~cond_q);
      if (clr_en_i) begin
        en_o <= 16'h0000;
      end else if (en_we_i) begin
        en_o <= (en_o & ~en_mask_i) | (en_wdat_i & en_mask_i);
      end
    end
  end

  // Summary is high while an enabled event is latched.
  assign sum_o = |(evt_o & en_o);
endmodule // ssr_status_group

// >>> design/ssr_status_top.v
// Purpose: Status groups, filtered error queue and system options.
// Assumes: One clock; classic Wishbone slave; rst_i is the power-up reset.
// Notes:   Commands are write pulses into the command register.
`include "ssr_map.vh"
module ssr_status_top #(
  parameter [2:0] SLOT_COUNT = `SSR_POS_SLOTS
) (
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave.
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Status conditions from the instrument.
  input  wire [15:0] meas_cond_i,
  input  wire [15:0] oper_cond_i,
  input  wire [15:0] ques_cond_i,
  // Error messages from the instrument.
  input  wire        err_valid_i,
  input  wire [15:0] err_msg_i,
  // Talk addressing.
  input  wire        talk_i,
  input  wire        active_chan_i,
  output reg         trig_ch1_o,
  output reg         trig_ch2_o,
  // System options and interrupt request.
  output wire [2:0]  power_on_setup_select_o,
  output wire        protocol_select_o,
  output wire        auto_zero_enable_o,
  output wire        cont_trig_o,
  output wire        display_on_o,
  output wire        irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  wire        req;
  wire        wr;
  wire        rd;
  wire [31:0] wmask;
  reg  [31:0] rdat_d;

  // A request counts once: the cycle in which ack is still low.
  assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr    = req & wb_we_i;
  assign rd    = req & ~wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Command pulses; only writes with the low byte lane count.
  wire cmd_wr = wr & (wb_adr_i == `SSR_A_CMD) & wb_sel_i[0];
  wire cls    = cmd_wr & wb_dat_i[`SSR_CMD_CLS];
  wire preset = cmd_wr & wb_dat_i[`SSR_CMD_PRE];
  wire qclr   = cmd_wr & wb_dat_i[`SSR_CMD_QCLR];
  // reset command ignored
  // The common reset command is handled elsewhere and has no path into
  // this block, so none of its state can be disturbed by it.

  ////////////////////////////////////////////////////////////////////////////
  // Status groups: measurement, operation, questionable.

  wire [47:0] cond_all;
  wire [47:0] evt_all;
  wire [47:0] en_all;
  wire [2:0]  sum_all;

  assign cond_all = {ques_cond_i, oper_cond_i, meas_cond_i};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : grp
      // Group base address, cut on purpose to the bus address width.
      wire [31:0] base_w = `SSR_A_GRP + g * `SSR_A_GSTEP;
      wire [7:0]  base   = base_w[7:0];
      wire en_we = wr & (wb_adr_i == base + `SSR_O_EN);
      ssr_status_group u_grp (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .cond_i    (cond_all[g*16 +: 16]),
        .clr_evt_i (cls),
        .clr_en_i  (preset),
        .en_we_i   (en_we),
        .en_mask_i (wmask[15:0]),
        .en_wdat_i (wb_dat_i[15:0]),
        .evt_o     (evt_all[g*16 +: 16]),
        .en_o      (en_all[g*16 +: 16]),
        .sum_o     (sum_all[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Error queue and message type filter.

  reg  [15:0] qen_q;
  reg  [15:0] qdis_q;
  wire [15:0] q_rdat;
  wire        q_empty;
  wire        q_full;
  wire        q_ovf;
  wire        q_pop;
  wire        q_push;
  wire [3:0]  msg_type;

  assign msg_type = err_msg_i[`SSR_TYPE_H:`SSR_TYPE_L];

  // type filter
  // The disabled list wins when a type sits on both lists.
  assign q_push = err_valid_i & qen_q[msg_type] & ~qdis_q[msg_type];

  // read removes
  // Both read ports pop, so a read returns an entry exactly once.
  assign q_pop = rd & ((wb_adr_i == `SSR_A_QNEXT) |
                       (wb_adr_i == `SSR_A_SYSERR));

  ssr_err_fifo u_fifo (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clr_i   (cls | qclr),
    .push_i  (q_push),
    .wdat_i  (err_msg_i),
    .pop_i   (q_pop),
    .rdat_o  (q_rdat),
    .empty_o (q_empty),
    .full_o  (q_full),
    .ovf_o   (q_ovf)
  );

  // lists power-up only
  // Neither clear-status nor preset touches the lists.
  always @(posedge clk_i) begin
    if (rst_i) begin
      qen_q  <= 16'h0000;
      qdis_q <= 16'h0000;
    end else begin
      if (wr & (wb_adr_i == `SSR_A_QEN)) begin
        qen_q <= (qen_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end
      if (wr & (wb_adr_i == `SSR_A_QDIS)) begin
        qdis_q <= (qdis_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System options.

  reg [2:0] pos_q;
  reg       prot_q;
  reg       az_q;
  reg       both_q;
  reg       cont_q;
  reg       disp_q;
  wire      sys_wr;
  wire [2:0] pos_w;

  assign sys_wr = wr & (wb_adr_i == `SSR_A_SYS) & wb_sel_i[0];
  assign pos_w  = wb_dat_i[`SSR_SYS_POS_H:`SSR_SYS_POS_L];

  // auto zero default on
  // A setup code past the last fitted slot is refused and the old one kept.
  always @(posedge clk_i) begin
    if (rst_i) begin
      pos_q  <= `SSR_POS_FACT;
      prot_q <= 1'b1;
      az_q   <= 1'b1;
      both_q <= 1'b0;
      cont_q <= 1'b0;
    end else if (sys_wr) begin
      if (pos_w <= SLOT_COUNT) begin
        pos_q <= pos_w;
      end
      prot_q <= wb_dat_i[`SSR_SYS_PROT];
      az_q   <= wb_dat_i[`SSR_SYS_AZ];
      both_q <= wb_dat_i[`SSR_SYS_BOTH];
      cont_q <= wb_dat_i[`SSR_SYS_CONT];
    end
  end

  // display follows mode
  // Only a change of the mode moves the display, so the display stays
  // where it is when the same mode value is written again.
  always @(posedge clk_i) begin
    if (rst_i) begin
      disp_q <= 1'b1;
    end else if (sys_wr & (wb_dat_i[`SSR_SYS_CONT] != cont_q)) begin
      disp_q <= ~wb_dat_i[`SSR_SYS_CONT];
    end
  end

  assign power_on_setup_select_o = pos_q;
  assign protocol_select_o       = prot_q;
  assign auto_zero_enable_o      = az_q;
  assign cont_trig_o             = cont_q;
  assign display_on_o            = disp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger on talk.

  // talk triggers
  // Channel one is selected when active_chan_i is low.
  always @(posedge clk_i) begin
    if (rst_i) begin
      trig_ch1_o <= 1'b0;
      trig_ch2_o <= 1'b0;
    end else begin
      trig_ch1_o <= talk_i & (both_q | ~active_chan_i);
      trig_ch2_o <= talk_i & (both_q | active_chan_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, enable and clear.

  reg  [`SSR_IRQ_W-1:0] irq_st_q;
  reg  [`SSR_IRQ_W-1:0] irq_en_q;
  reg                   sum_q;
  wire [`SSR_IRQ_W-1:0] irq_set;
  wire [`SSR_IRQ_W-1:0] irq_clr;
  wire                  sum_any;

  assign sum_any = |sum_all;

  // Queued message, dropped push, and a new enabled status summary.
  assign irq_set = {sum_any & ~sum_q, q_ovf, q_push & (~q_full | q_pop)};
  assign irq_clr = (wr & (wb_adr_i == `SSR_A_IRQCLR) & wb_sel_i[0]) ?
                   wb_dat_i[`SSR_IRQ_W-1:0] : 3'h0;

  // A set in the same cycle as its clear wins, so no event is lost.
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_q <= 3'h0;
      irq_en_q <= 3'h0;
      sum_q    <= 1'b0;
    end else begin
      sum_q    <= sum_any;
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
      if (wr & (wb_adr_i == `SSR_A_IRQEN) & wb_sel_i[0]) begin
        irq_en_q <= wb_dat_i[`SSR_IRQ_W-1:0];
      end
    end
  end

  assign irq_o = |(irq_st_q & irq_en_q);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux.

  // Group registers are found by offset within a sixteen byte stride.
  wire [7:0] goff = wb_adr_i - `SSR_A_GRP;
  wire [1:0] gsel = goff[5:4];
  wire [3:0] greg = goff[3:0];
  wire       g_hit = (wb_adr_i >= `SSR_A_GRP) & (wb_adr_i < `SSR_A_QNEXT);

  always @* begin
    rdat_d = 32'h0000_0000;
    if (g_hit & (gsel != 2'h3)) begin
      if (greg == `SSR_O_EVT) begin
        rdat_d[15:0] = evt_all[gsel*16 +: 16];
      end else if (greg == `SSR_O_EN) begin
        rdat_d[15:0] = en_all[gsel*16 +: 16];
      end else if (greg == `SSR_O_COND) begin
        rdat_d[15:0] = cond_all[gsel*16 +: 16];
      end
    end else if ((wb_adr_i == `SSR_A_QNEXT) | (wb_adr_i == `SSR_A_SYSERR)) begin
      // Valid flag low means the queue had nothing to give.
      rdat_d[`SSR_Q_VALID] = ~q_empty;
      rdat_d[15:0]         = q_empty ? 16'h0000 : q_rdat;
    end else if (wb_adr_i == `SSR_A_QEN) begin
      rdat_d[15:0] = qen_q;
    end else if (wb_adr_i == `SSR_A_QDIS) begin
      rdat_d[15:0] = qdis_q;
    end else if (wb_adr_i == `SSR_A_SYS) begin
      rdat_d[`SSR_SYS_POS_H:`SSR_SYS_POS_L] = pos_q;
      rdat_d[`SSR_SYS_PROT] = prot_q;
      rdat_d[`SSR_SYS_AZ]   = az_q;
      rdat_d[`SSR_SYS_BOTH] = both_q;
      rdat_d[`SSR_SYS_CONT] = cont_q;
      rdat_d[`SSR_SYS_DISP] = disp_q;
    end else if (wb_adr_i == `SSR_A_IRQST) begin
      rdat_d[`SSR_IRQ_W-1:0] = irq_st_q;
    end else if (wb_adr_i == `SSR_A_IRQEN) begin
      rdat_d[`SSR_IRQ_W-1:0] = irq_en_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge.

  // Every address is answered one cycle after the request; unmapped ones
  // read zero and ignore writes, so a stray access never hangs the bus.
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (rd) begin
        wb_dat_o <= rdat_d;
      end
    end
  end

endmodule // ssr_status_top

// >>> dv/ssr_host_model.sv
// Purpose: Host side of the register bus, a classic Wishbone master.
// Assumes: Slave answers with a registered one-cycle ack.
// Notes:   The wait has no bound here; the bench timeout ends a hang.
module ssr_host_model (
  input  wire         clk_i,
  input  wire  [31:0] wb_dat_i,
  input  wire         wb_ack_i,
  output logic        wb_cyc_o,
  output logic        wb_stb_o,
  output logic        wb_we_o,
  output logic [7:0]  wb_adr_o,
  output logic [3:0]  wb_sel_o,
  output logic [31:0] wb_dat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus from time zero.
  initial begin
    {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
  end
  ////////////////////////////////////////////////////////////
  // One single cycle; the request is held until ack is seen, so a slow slave is fine.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= w;
    wb_adr_o <= a;
    wb_sel_o <= 4'hF;
    wb_dat_o <= d;
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o  <= 1'b0;
  endtask
endmodule // ssr_host_model

// >>> dv/ssr_status_asserts.sv
// Purpose: Port-level checks of the status and error block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound into ssr_status_top after the module.
module ssr_status_asserts #(
  parameter [2:0] SLOT_COUNT = 3'h5
) (
  input wire       clk_i,
  input wire       rst_i,
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_we_i,
  input wire       wb_ack_o,
  input wire       talk_i,
  input wire       active_chan_i,
  input wire       trig_ch1_o,
  input wire       trig_ch2_o,
  input wire [2:0] power_on_setup_select_o,
  input wire       protocol_select_o,
  input wire       auto_zero_enable_o,
  input wire       cont_trig_o,
  input wire       display_on_o,
  input wire       irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////
  // A taken request is answered at the very next edge, for one cycle only.
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  // Triggers only follow a talk request, and the active channel always fires.
  chk_trig_src: assert property (trig_ch1_o || trig_ch2_o |-> $past(talk_i))
    else $error("stray trigger");
  chk_trig_active: assert property (talk_i |=> ($past(active_chan_i) ? trig_ch2_o : trig_ch1_o))
    else $error("active channel idle");
  // Continuous mode and display move in opposite directions.
  chk_disp_off: assert property ($rose(cont_trig_o) |-> !display_on_o)
    else $error("display stayed on");
  chk_disp_on: assert property ($fell(cont_trig_o) |-> display_on_o)
    else $error("display stayed off");
  chk_pos_range: assert property (power_on_setup_select_o <= SLOT_COUNT)
    else $error("setup code out of range");
  // Options come out of power-up at their defaults.
  chk_reset_dflt: assert property ($fell(rst_i) |-> protocol_select_o && auto_zero_enable_o
    && !cont_trig_o && display_on_o && power_on_setup_select_o == 3'h0 && !irq_o)
    else $error("bad power-up options");
  // Options move only after a bus write, never on their own.
  chk_opts_bus: assert property (!$stable({power_on_setup_select_o, protocol_select_o,
    auto_zero_enable_o, cont_trig_o, display_on_o}) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i))
    else $error("option moved without write");
endmodule // ssr_status_asserts

bind ssr_status_top ssr_status_asserts #(.SLOT_COUNT(SLOT_COUNT)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .talk_i(talk_i), .active_chan_i(active_chan_i),
  .trig_ch1_o(trig_ch1_o), .trig_ch2_o(trig_ch2_o),
  .power_on_setup_select_o(power_on_setup_select_o), .protocol_select_o(protocol_select_o),
  .auto_zero_enable_o(auto_zero_enable_o), .cont_trig_o(cont_trig_o),
  .display_on_o(display_on_o), .irq_o(irq_o));

// >>> dv/tb.sv
// Purpose: Self-checking bench of the status and error block.
// Assumes: 250 MHz clock, reset held eight cycles.
// Notes:   Queue contents are predicted by a queue model.
`include "ssr_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [15:0] cond [3] = '{default: 16'h0};
  logic        err_valid = 1'b0;
  logic [15:0] err_msg = 16'h0;
  logic        talk = 1'b0;
  logic        act = 1'b0;
  wire         cyc, stb, we, ack, t1, t2, prot, az, cont, disp, irq;
  wire  [7:0]  adr;
  wire  [3:0]  sel;
  wire  [31:0] wdat, rdat;
  wire  [2:0]  pos;
  int          bad_count, num_checks, cyc_cnt;
  logic [15:0] lfsr_q = 16'h5C6E;
  logic [15:0] qen, qdis;
  logic [15:0] mq [$];
  logic [7:0]  ba;
  logic [31:0] exp;

  always #2 clk_i = ~clk_i;

  ssr_host_model i_host (.clk_i(clk_i), .wb_dat_i(rdat), .wb_ack_i(ack), .wb_cyc_o(cyc),
    .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));
  ssr_status_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .meas_cond_i(cond[0]), .oper_cond_i(cond[1]), .ques_cond_i(cond[2]),
    .err_valid_i(err_valid), .err_msg_i(err_msg), .talk_i(talk), .active_chan_i(act),
    .trig_ch1_o(t1), .trig_ch2_o(t2), .power_on_setup_select_o(pos),
    .protocol_select_o(prot), .auto_zero_enable_o(az), .cont_trig_o(cont),
    .display_on_o(disp), .irq_o(irq));
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    num_checks++;
    if (got !== e) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_host.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_host.xfer(1'b1, a, d, q);
    if (a == `SSR_A_CMD && (d[`SSR_CMD_CLS] || d[`SSR_CMD_QCLR])) mq.delete();
  endtask
  // Pushes a message; the model keeps it only if its type passes both lists and room remains.
  task automatic push(input logic [15:0] m);
    @(posedge clk_i);
    err_valid <= 1'b1;
    err_msg <= m;
    if (qen[m[15:12]] && !qdis[m[15:12]] && mq.size() < 8) mq.push_back(m);
    @(posedge clk_i);
    err_valid <= 1'b0;
  endtask
  task automatic pop(input logic [7:0] a);
    exp = mq.size() ? {16'h8000, mq.pop_front()} : 32'h0;
    rd(a, exp);
  endtask
  task automatic tlk(input logic c, input logic [1:0] e);
    @(posedge clk_i);
    talk <= 1'b1;
    act <= c;
    @(posedge clk_i);
    talk <= 1'b0;
    #1 chk({30'h0, t1, t2}, {30'h0, e});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // A hang counts as a mismatch and still reaches the report.
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      bad_count++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`SSR_A_SYS, 32'h98);
    rd(`SSR_A_QEN, 32'h0);
    wr(8'h7C, 32'hFFFF_FFFF);
    rd(8'h7C, 32'h0);
    // Each group: enable readback, latched events, then preset and clear-status.
    for (int g = 0; g < 3; g++) begin
      ba = `SSR_A_GRP + (8'(g) << 4);
      lfsr_q = nxt(lfsr_q);
      wr(ba + `SSR_O_EN, {16'h0, lfsr_q});
      rd(ba + `SSR_O_EN, {16'h0, lfsr_q});
      @(posedge clk_i) cond[g] <= lfsr_q;
      rd(ba + `SSR_O_COND, {16'h0, lfsr_q});
      @(posedge clk_i) cond[g] <= 16'h0;
      repeat (2) @(posedge clk_i);
      rd(ba + `SSR_O_EVT, {16'h0, lfsr_q});
      wr(`SSR_A_CMD, 32'h2);
      rd(ba + `SSR_O_EN, 32'h0);
      rd(ba + `SSR_O_EVT, {16'h0, lfsr_q});
      wr(ba + `SSR_O_EN, {16'h0, lfsr_q});
      wr(`SSR_A_CMD, 32'h1);
      rd(ba + `SSR_O_EVT, 32'h0);
      rd(ba + `SSR_O_EN, {16'h0, lfsr_q});
    end
    // Filtered pushes overflow the store, then drain oldest first on both pop ports.
    qen = 16'h00FF;
    qdis = 16'h0F0F;
    wr(`SSR_A_QEN, {16'h0, qen});
    wr(`SSR_A_QDIS, {16'h0, qdis});
    for (int i = 0; i < 40; i++) begin
      lfsr_q = nxt(lfsr_q);
      push({4'(i % 8), lfsr_q[11:0]});
    end
    // Queued and overflow bits, plus the summary bit raised by the group loop.
    rd(`SSR_A_IRQST, 32'h7);
    for (int i = 0; i < 9; i++) pop(i[0] ? `SSR_A_SYSERR : `SSR_A_QNEXT);
    // Interrupt raised, masked and cleared.
    wr(`SSR_A_IRQCLR, 32'h7);
    wr(`SSR_A_IRQEN, 32'h1);
    push(16'h4ABC);
    // The status bit is set at the push edge; look once it has settled.
    @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    wr(`SSR_A_IRQEN, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(`SSR_A_IRQEN, 32'h1);
    wr(`SSR_A_IRQCLR, 32'h1);
    chk({31'h0, irq}, 32'h0);
    // Preset keeps the queue, clear-status and queue clear empty it.
    push(16'h5123);
    wr(`SSR_A_CMD, 32'h2);
    pop(`SSR_A_QNEXT);
    wr(`SSR_A_CMD, 32'h1);
    pop(`SSR_A_QNEXT);
    push(16'h6001);
    wr(`SSR_A_CMD, 32'h4);
    pop(`SSR_A_QNEXT);
    rd(`SSR_A_QDIS, {16'h0, qdis});
    // Power-on setup codes, the last one out of range and ignored.
    for (int p = 0; p < 7; p++) begin
      wr(`SSR_A_SYS, 32'h08 | p);
      exp = 32'h88 | (p > 5 ? 32'h5 : p);
      rd(`SSR_A_SYS, exp);
      chk({29'h0, pos}, exp & 32'h7);
    end
    wr(`SSR_A_SYS, 32'h60);
    rd(`SSR_A_SYS, 32'h60);
    chk({29'h0, az, prot, disp}, 32'h0);
    tlk(1'b1, 2'b11);
    wr(`SSR_A_SYS, 32'h18);
    rd(`SSR_A_SYS, 32'h98);
    tlk(1'b1, 2'b01);
    tlk(1'b0, 2'b10);
    summarize();
  end
endmodule // tb
